/* File: rtl/pes_blink_if.sv */
/*
  Carrier between the status top and its lamp blinker.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/10ps
interface pes_blink_if;
  pes_pkg::pes_lamp_t lampMode;
  logic phase;
  logic lamp;
  modport gen (input lampMode, output phase, output lamp);
  modport user (output lampMode, input phase, input lamp);
endinterface

/* File: rtl/pes_blinker.sv */
/*
  Lamp blinker: prescales sys_clk into a visible blink phase and drives the lamp.
  Assumes a synchronised active-low reset and a shared clock enable.
*/
`timescale 1ns/10ps
`include "pes_regs.svh"
module pes_blinker #(
  parameter int unsigned BLINK_HALF_CYC = `PES_BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sysRst_n,
  input wire logic clk_en,
  // lamp carrier
  pes_blink_if.gen lnk
);
  import pes_pkg::*;

  localparam logic [`PES_CNT_W-1:0] HALF_LAST = `PES_CNT_W'(BLINK_HALF_CYC - 1);

  logic [`PES_CNT_W-1:0] preCnt;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      preCnt <= '0;
      lnk.phase <= 1'b0;
    end else if (clk_en) begin
      if (preCnt == HALF_LAST) begin
        preCnt <= '0;
        lnk.phase <= ~lnk.phase;
      end else begin
        preCnt <= preCnt + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // lamp driver
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      lnk.lamp <= 1'b0;
    end else if (clk_en) begin
      unique case (lnk.lampMode)
        PES_LAMP_STEADY: lnk.lamp <= 1'b1;
        PES_LAMP_BLINK: lnk.lamp <= lnk.phase;
        PES_LAMP_OFF: lnk.lamp <= 1'b0;
        default: lnk.lamp <= 1'b0;
      endcase
    end
  end
endmodule

/* File: rtl/pes_pkg.sv */
/*
  Types of the programmer status indicator.
  Assumes nothing of its surroundings.
*/
package pes_pkg;
  typedef enum logic [1:0] {
    PES_LAMP_OFF,
    PES_LAMP_STEADY,
    PES_LAMP_BLINK
  } pes_lamp_t;

  typedef enum logic [2:0] {
    PES_IDLE,
    PES_QUAL,
    PES_WAIT_TGT,
    PES_RUN,
    PES_PASS,
    PES_FAIL
  } pes_state_t;
endpackage

/* File: rtl/pes_regs.svh */
/*
  Constants of the programmer status indicator: bus offsets, field positions,
  reset values and timing counts.
  Assumes a 40 MHz system clock and that the firmware reports its events over APB.
*/
`ifndef PES_REGS_SVH
`define PES_REGS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PES_CLK_HZ 40000000
`define PES_START_MIN_MS 200
`define PES_START_MIN_CYC ((`PES_CLK_HZ / 1000) * `PES_START_MIN_MS)
`define PES_BLINK_HALF_MS 250
`define PES_BLINK_HALF_CYC ((`PES_CLK_HZ / 1000) * `PES_BLINK_HALF_MS)
`define PES_CNT_W 24

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PES_OFF_EVENT 12'h000
`define PES_OFF_CTRL 12'h004
`define PES_OFF_STATUS 12'h008

// ---------------------------------------------------------------
// event register bits, write one to report
// ---------------------------------------------------------------
`define PES_EV_BOOT_OK 0
`define PES_EV_BOOT_FAIL 1
`define PES_EV_CRC_OK 2
`define PES_EV_CRC_FAIL 3
`define PES_EV_TGT_OK 4
`define PES_EV_TGT_NORESP 5
`define PES_EV_VERIFY_OK 6
`define PES_EV_VERIFY_FAIL 7
`define PES_EV_W 8

// ---------------------------------------------------------------
// control and status fields
// ---------------------------------------------------------------
`define PES_CTRL_START_EN 0
`define PES_CTRL_RESET 1'h1
`define PES_ST_BURN 0
`define PES_ST_GOOD 1
`define PES_ST_BAD 2
`define PES_ST_LAMP 3
`define PES_ST_BOOT_OK 4
`define PES_ST_BOOT_FAIL 5
`define PES_ST_CRC_ERR 6
`define PES_ST_MEMSEL_BAD 7
`define PES_ST_MEMSEL_LO 8
`define PES_ST_START 11
`define PES_ST_WAIT_TGT 12

// ---------------------------------------------------------------
// selector positions
// ---------------------------------------------------------------
`define PES_MEMSEL_BAD_A 3'h6
`define PES_MEMSEL_BAD_B 3'h7

`endif

/* File: rtl/pes_status_top.sv */
/*
  Status and error reporting of a standalone flash programmer: red error lamp,
  test-connector start input and busy / good / bad outputs, with an APB slave
  through which the programmer firmware reports its events.
  Assumes start_request_in and mem_size_sel come from pins, APB runs on sys_clk.
*/
`timescale 1ns/10ps
`include "pes_regs.svh"
module pes_status_top #(
  parameter int unsigned START_MIN_CYC = `PES_START_MIN_CYC,
  parameter int unsigned BLINK_HALF_CYC = `PES_BLINK_HALF_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // test connector and front panel
  input wire logic start_request_in,
  input wire logic [2:0] mem_size_sel,
  output logic burn_in_progress,
  output logic verify_good_out,
  output logic verify_bad_out,
  output logic error_lamp
);
  import pes_pkg::*;

  localparam logic [`PES_CNT_W-1:0] START_LAST = `PES_CNT_W'(START_MIN_CYC - 1);

  logic rstMeta_n;
  logic sysRst_n;
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic startLvl;
  logic startPrev;
  logic [2:0] memSel;
  logic memselBad;
  logic addrHit;
  logic apbWrite;
  logic [`PES_EV_W-1:0] evt;
  logic startEn;
  logic bootOk;
  logic bootFail;
  logic crcErr;
  logic runAllowed;
  logic [`PES_CNT_W-1:0] startCnt;
  pes_state_t state;
  pes_state_t next_state;
  pes_blink_if blk ();

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      sysRst_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      sysRst_n <= rstMeta_n;
    end
  end

  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      startPrev <= 1'b0;
    end else if (clk_en) begin
      pinMeta <= {start_request_in, mem_size_sel};
      pinSync <= pinMeta;
      startPrev <= pinSync[3];
    end
  end

  assign startLvl = pinSync[3];
  assign memSel = pinSync[2:0];
  assign memselBad = (memSel == `PES_MEMSEL_BAD_A) || (memSel == `PES_MEMSEL_BAD_B);

  // ---------------------------------------------------------------
  // apb slave, zero wait states, read data registered in setup
  // ---------------------------------------------------------------
  assign addrHit = (paddr == `PES_OFF_EVENT) || (paddr == `PES_OFF_CTRL) ||
                   (paddr == `PES_OFF_STATUS);
  assign pready = psel & penable & clk_en;
  assign pslverr = pready & ~addrHit;
  assign apbWrite = pready & pwrite;
  assign evt = (apbWrite && paddr == `PES_OFF_EVENT) ? pwdata[`PES_EV_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      startEn <= `PES_CTRL_RESET;
    end else if (apbWrite && paddr == `PES_OFF_CTRL) begin
      startEn <= pwdata[`PES_CTRL_START_EN];
    end
  end

  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (paddr == `PES_OFF_CTRL) begin
        prdata[`PES_CTRL_START_EN] <= startEn;
      end else if (paddr == `PES_OFF_STATUS) begin
        prdata[`PES_ST_BURN] <= burn_in_progress;
        prdata[`PES_ST_GOOD] <= verify_good_out;
        prdata[`PES_ST_BAD] <= verify_bad_out;
        prdata[`PES_ST_LAMP] <= error_lamp;
        prdata[`PES_ST_BOOT_OK] <= bootOk;
        prdata[`PES_ST_BOOT_FAIL] <= bootFail;
        prdata[`PES_ST_CRC_ERR] <= crcErr;
        prdata[`PES_ST_MEMSEL_BAD] <= memselBad;
        prdata[`PES_ST_MEMSEL_LO +: 3] <= memSel;
        prdata[`PES_ST_START] <= startLvl;
        prdata[`PES_ST_WAIT_TGT] <= (state == PES_WAIT_TGT);
      end
    end
  end

  // ---------------------------------------------------------------
  // power-up and image health
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      bootOk <= 1'b0;
      bootFail <= 1'b0;
    end else if (clk_en) begin
      if (evt[`PES_EV_BOOT_FAIL]) begin
        bootFail <= 1'b1;
        bootOk <= 1'b0;
      end else if (evt[`PES_EV_BOOT_OK] && !bootFail) begin
        bootOk <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      crcErr <= 1'b0;
    end else if (clk_en) begin
      if (evt[`PES_EV_CRC_FAIL]) begin
        crcErr <= 1'b1;
      end else if (evt[`PES_EV_CRC_OK]) begin
        crcErr <= 1'b0;
      end
    end
  end

  assign runAllowed = startEn & bootOk & ~crcErr & ~memselBad;

  // ---------------------------------------------------------------
  // start qualification counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      startCnt <= '0;
    end else if (clk_en) begin
      if (state != PES_QUAL) begin
        startCnt <= '0;
      end else if (startCnt != START_LAST) begin
        startCnt <= startCnt + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // run sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      PES_IDLE, PES_PASS, PES_FAIL: begin
        if (startLvl && !startPrev) begin
          next_state = PES_QUAL;
        end
      end
      PES_QUAL: begin
        if (!startLvl) begin
          next_state = PES_IDLE;
        end else if (startCnt == START_LAST && runAllowed) begin
          next_state = PES_WAIT_TGT;
        end
      end
      PES_WAIT_TGT: begin
        if (evt[`PES_EV_TGT_NORESP]) begin
          next_state = PES_FAIL;
        end else if (evt[`PES_EV_TGT_OK]) begin
          next_state = PES_RUN;
        end
      end
      PES_RUN: begin
        if (evt[`PES_EV_VERIFY_FAIL]) begin
          next_state = PES_FAIL;
        end else if (evt[`PES_EV_VERIFY_OK]) begin
          next_state = PES_PASS;
        end
      end
      default: next_state = PES_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      state <= PES_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // test connector outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      burn_in_progress <= 1'b0;
      verify_good_out <= 1'b0;
      verify_bad_out <= 1'b0;
    end else if (clk_en) begin
      burn_in_progress <= (next_state == PES_RUN);
      verify_bad_out <= (next_state == PES_FAIL);
      verify_good_out <= (next_state == PES_PASS) ||
                         (next_state == PES_RUN && blk.phase);
    end
  end

  // ---------------------------------------------------------------
  // red lamp
  // ---------------------------------------------------------------
  always_comb begin
    if (!bootOk || crcErr || state == PES_FAIL) begin
      blk.lampMode = PES_LAMP_STEADY;
    end else if (memselBad) begin
      blk.lampMode = PES_LAMP_BLINK;
    end else begin
      blk.lampMode = PES_LAMP_OFF;
    end
  end

  pes_blinker #(
    .BLINK_HALF_CYC(BLINK_HALF_CYC)
  ) u_blinker (
    .sys_clk(sys_clk),
    .sysRst_n(sysRst_n),
    .clk_en(clk_en),
    .lnk(blk)
  );

  assign error_lamp = blk.lamp;
endmodule

/* File: verif/pes_ate_model.sv */
/*
  Factory test controller model driving the start pin.
  Assumes the bench pulses go for one cycle to begin a run.
*/
`timescale 1ns/10ps
module pes_ate_model #(
  parameter int MIN_CYC = 20
) (
  // clock and bench command
  input wire logic sys_clk,
  input wire logic go,
  // status from the block
  input wire logic burn_in_progress,
  input wire logic verify_bad_out,
  // start pin, pulled down when released
  output logic start_request_in
);
  int heldCnt;
  initial start_request_in = 1'b0;
  initial heldCnt = 0;
  always @(posedge sys_clk) begin
    if (go) begin
      start_request_in <= 1'b1;
      heldCnt <= 0;
    end else if (start_request_in) begin
      heldCnt <= heldCnt + 1;
      if (heldCnt >= MIN_CYC && (burn_in_progress || verify_bad_out)) begin
        start_request_in <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/pes_status_top_monitor.sv */
/*
  Checker of the programmer status indicator, bound to its top module.
  Assumes the bench keeps clk_en high.
*/
`timescale 1ns/10ps
module pes_status_top_monitor #(
  parameter int unsigned BLINK_HALF_CYC = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // test connector and lamp
  input wire logic start_request_in,
  input wire logic burn_in_progress,
  input wire logic verify_good_out,
  input wire logic verify_bad_out,
  input wire logic error_lamp
);
  int unsigned holdCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // cycles the good output has stood still during a run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) holdCnt <= 0;
    else if (!burn_in_progress || $changed(verify_good_out)) holdCnt <= 0;
    else holdCnt <= holdCnt + 1;
  end
  sequence lampHeld;
    error_lamp [*2];
  endsequence
  a_ready_zero_wait: assert property (pready == (psel && penable && clk_en))
    else $error("pready not zero wait");
  a_err_in_access: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_bad_lamp_lit: assert property ($rose(verify_bad_out) |=> lampHeld)
    else $error("lamp not lit on failure");
  a_bad_no_burn: assert property (verify_bad_out |-> !burn_in_progress)
    else $error("busy high with bad");
  a_pass_good_high: assert property ($fell(burn_in_progress) && !verify_bad_out |-> verify_good_out)
    else $error("good not high on pass");
  a_start_clears: assert property ($rose(start_request_in) && !burn_in_progress
    |-> ##[1:6] !verify_good_out && !verify_bad_out)
    else $error("start did not clear results");
  a_run_not_bad: assert property ($rose(burn_in_progress) |-> !verify_bad_out)
    else $error("run began with bad");
  a_good_toggles: assert property (holdCnt <= BLINK_HALF_CYC)
    else $error("good not toggling in run");
endmodule
bind pes_status_top pes_status_top_monitor #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) mon_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .start_request_in(start_request_in),
  .burn_in_progress(burn_in_progress), .verify_good_out(verify_good_out),
  .verify_bad_out(verify_bad_out), .error_lamp(error_lamp));

/* File: verif/tb.sv */
/*
  Self-checking bench of the programmer status indicator.
  Assumes firmware events arrive over APB and the test controller model drives start.
*/
`timescale 1ns/10ps
`include "pes_regs.svh"
module tb;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic startReq, burn, good, bad, lamp, err;
  logic [2:0] memSel;
  logic [1:0] seen;
  int num_errors, check_count;
  always #12.5 sys_clk = ~sys_clk;
  pes_status_top #(.START_MIN_CYC(20), .BLINK_HALF_CYC(4)) pes_status_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_request_in(startReq), .mem_size_sel(memSel),
    .burn_in_progress(burn), .verify_good_out(good), .verify_bad_out(bad),
    .error_lamp(lamp));
  pes_ate_model #(.MIN_CYC(20)) pes_ate_model_i (.sys_clk(sys_clk), .go(go),
    .burn_in_progress(burn), .verify_bad_out(bad), .start_request_in(startReq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic fire(input int b);
    apb(`PES_OFF_EVENT, 1'b1, 32'h0000_0001 << b);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic steady();
    int n;
    n = 0;
    cyc(1);
    repeat (10) begin
      @(posedge sys_clk);
      if (lamp !== 1'b1) n++;
    end
    chk(n, 0);
  endtask
  // which selects the watched output: 0 lamp, 1 good
  task automatic sample(input int which, input int n);
    logic s;
    seen = 2'b00;
    repeat (n) begin
      @(posedge sys_clk);
      s = (which == 0) ? lamp : good;
      if (s === 1'b0) seen[0] = 1'b1;
      if (s === 1'b1) seen[1] = 1'b1;
    end
  endtask
  task automatic startRun();
    int n;
    n = 0;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    do begin
      apb(`PES_OFF_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end while (rd[`PES_ST_WAIT_TGT] !== 1'b1 && n < 40);
    chk(rd[`PES_ST_WAIT_TGT], 1'b1);
    chk({good, bad, burn}, 3'b000);
  endtask
  task automatic tBoot();
    cyc(4);
    chk(lamp, 1'b1);
    apb(`PES_OFF_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(12'h00C, 1'b0, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    fire(`PES_EV_BOOT_OK);
    cyc(2);
    chk(lamp, 1'b0);
    $display("boot test done");
  endtask
  task automatic tMemsel();
    for (int v = 6; v <= 7; v++) begin
      memSel <= 3'(v);
      cyc(6);
      sample(0, 24);
      chk(seen, 2'b11);
    end
    memSel <= 3'h0;
    cyc(8);
    chk(lamp, 1'b0);
    $display("selector test done");
  endtask
  task automatic tCrc();
    fire(`PES_EV_CRC_FAIL);
    steady();
    fire(`PES_EV_CRC_OK);
    cyc(2);
    chk(lamp, 1'b0);
    $display("crc test done");
  endtask
  task automatic tRun(input logic fail);
    startRun();
    fire(`PES_EV_TGT_OK);
    cyc(2);
    chk(burn, 1'b1);
    sample(1, 12);
    chk(seen, 2'b11);
    fire(fail ? `PES_EV_VERIFY_FAIL : `PES_EV_VERIFY_OK);
    cyc(2);
    chk({burn, good, bad, lamp}, fail ? 4'b0011 : 4'b0100);
    if (fail) steady();
    $display("run test done");
  endtask
  task automatic tNoResp();
    startRun();
    fire(`PES_EV_TGT_NORESP);
    chk({burn, bad}, 2'b01);
    steady();
    $display("no response test done");
  endtask
  task automatic tBootFail();
    fire(`PES_EV_BOOT_FAIL);
    fire(`PES_EV_BOOT_OK);
    apb(`PES_OFF_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_002C);
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(4);
    chk(lamp, 1'b1);
    apb(`PES_OFF_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    fire(`PES_EV_BOOT_OK);
    cyc(2);
    chk(lamp, 1'b0);
    $display("power-up fault test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, go} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    memSel = 3'h0;
    cyc(20);
    rst_n <= 1'b1;
    tBoot();
    tMemsel();
    tCrc();
    tRun(1'b0);
    tRun(1'b1);
    tNoResp();
    tBootFail();
    end_sim();
  end
  initial begin
    cyc(20000);
    num_errors++;
    end_sim();
  end
endmodule
